// File: common/eamg_regs.svh
// Register offsets, field positions and reset values of the metering bank
`ifndef EAMG_REGS_SVH
`define EAMG_REGS_SVH

`define EAMG_ADDR_ACC_MODE 8'h0F
`define EAMG_ADDR_GAIN 8'h1B
`define EAMG_ADDR_IRQ_EN_LOW 8'hD9
`define EAMG_ADDR_IRQ_ST_LOW 8'hDC

`define EAMG_ACC_RESV_HI 7
`define EAMG_ACC_RESV_LO 6
`define EAMG_ACC_VAR_SIGN_EVT 5
`define EAMG_ACC_AP_SIGN_EVT 4
`define EAMG_ACC_VAR_ABS 3
`define EAMG_ACC_VAR_BY_AP 2
`define EAMG_ACC_AP_POS_ONLY 1
`define EAMG_ACC_AP_ABS 0

`define EAMG_GAIN_V_HI 7
`define EAMG_GAIN_V_LO 5
`define EAMG_GAIN_SIGN_SRC 3
`define EAMG_GAIN_I_HI 2
`define EAMG_GAIN_I_LO 0

`define EAMG_ST_SUMMARY 7
`define EAMG_ST_VAR_SIGN 4
`define EAMG_ST_AP_SIGN 3
`define EAMG_ST_VA_NOLOAD 2
`define EAMG_ST_VAR_NOLOAD 1
`define EAMG_ST_AP_NOLOAD 0
`define EAMG_ST_FLAGS 5

`define EAMG_ACC_MODE_RST 8'h00
`define EAMG_GAIN_RST 8'h00
`define EAMG_IRQ_EN_RST 5'h00
`define EAMG_IRQ_ST_RST 5'h00

`endif

// File: common/eamg_pkg.sv
// Types shared by the metering configuration and status bank
package eamg_pkg;
  typedef logic signed [23:0] eamg_power_t;
  typedef logic [2:0] eamg_gain_code_t;
  typedef enum logic {
    EAMG_SRC_FILTERED,
    EAMG_SRC_PULSE
  } eamg_sign_src_t;
endpackage

// File: common/eamg_sign_if.sv
// Connection between the bank and one sign-change detector
`timescale 1ns/1ps
interface eamg_sign_if;
  logic strobe;
  logic neg;
  logic dir_rising;
  logic evt;
  modport det (input strobe, input neg, input dir_rising, output evt);
  modport ctl (output strobe, output neg, output dir_rising, input evt);
endinterface

// File: src/eamg_sign_det.sv
// Sign-change detector raising an event in one selected direction
`timescale 1ns/1ps
module eamg_sign_det (
  input wire logic clk_sys,
  input wire logic rst_b,
  eamg_sign_if.det sif
);
  logic prev_neg_reg;
  logic have_prev_reg;
  logic evt_reg;
  logic change;

  assign sif.evt = evt_reg;

  // ------------------------------------------------------------
  // Sign history
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prev_neg_reg <= 1'b0;
      have_prev_reg <= 1'b0;
    end else if (sif.strobe) begin
      prev_neg_reg <= sif.neg;
      have_prev_reg <= 1'b1;
    end
  end

  // Direction 0: positive to negative, 1: negative to positive
  assign change = sif.dir_rising ? (prev_neg_reg && !sif.neg)
                                 : (!prev_neg_reg && sif.neg);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      evt_reg <= 1'b0;
    end else begin
      evt_reg <= sif.strobe && have_prev_reg && change;
    end
  end

  property p_dir_event;
    @(posedge clk_sys) disable iff (!rst_b)
    (sif.strobe && have_prev_reg && !sif.dir_rising && !prev_neg_reg
     && sif.neg) |=> evt_reg;
  endproperty
  a_dir_event: assert property (p_dir_event)
    else $error("falling sign change raised no event");

  property p_no_wrong_dir;
    @(posedge clk_sys) disable iff (!rst_b)
    (sif.strobe && sif.dir_rising && !prev_neg_reg) |=> !evt_reg;
  endproperty
  a_no_wrong_dir: assert property (p_no_wrong_dir)
    else $error("event raised for unselected direction");
endmodule

// File: src/eamg_top.sv
// Accumulation mode, gain select and first metering status bank
//
// Notes on behaviour
// - Reactive sign event direction chosen by bit 5
// - Active sign event direction chosen by bit 4
// - Bit 3 accumulates absolute reactive power
// - Bit 2 inverts reactive while active is negative
// - Sign-dependent mode feeds both accumulators and pulse
// - Bit 1 accumulates only positive active power
// - Bit 0 accumulates absolute active power
// - Voltage gain code in bits 7 to 5
// - Current gain code in bits 2 to 0
// - Bit 3 picks filtered or per-pulse sign detection
// - Summary bit follows any enabled set flag
// - Status bit 4 flags reactive sign change
// - Status bit 3 flags active sign change
// - Status bit 2 flags apparent or rms no-load
// - Status bit 1 flags reactive no-load
// - Status bit 0 flags active no-load
// - Enable bits gate flags into pending interrupt
`timescale 1ns/1ps
`include "eamg_regs.svh"
module eamg_top (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire eamg_pkg::eamg_power_t active_power,
  input wire eamg_pkg::eamg_power_t reactive_power,
  input wire logic power_valid,
  input wire logic energy_pulse,
  input wire logic pulse_on_reactive,
  input wire logic active_noload_det,
  input wire logic reactive_noload_det,
  input wire logic apparent_noload_det,
  input wire logic irms_noload_enter,
  output eamg_pkg::eamg_power_t active_energy_inc,
  output eamg_pkg::eamg_power_t reactive_energy_inc,
  output logic energy_inc_valid,
  output eamg_pkg::eamg_power_t energy_pulse_power,
  output eamg_pkg::eamg_gain_code_t voltage_gain_sel,
  output eamg_pkg::eamg_gain_code_t current_gain_sel,
  output eamg_pkg::eamg_sign_src_t sign_detect_source,
  output logic metering_irq
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [7:0] acc_mode_reg;
  eamg_pkg::eamg_gain_code_t v_gain_reg;
  eamg_pkg::eamg_gain_code_t i_gain_reg;
  eamg_pkg::eamg_sign_src_t sign_src_reg;
  logic [4:0] irq_en_reg;
  logic [4:0] irq_en_next;
  logic [4:0] status_reg;
  logic [4:0] status_next;
  logic [4:0] status_set;
  logic summary_reg;
  logic [7:0] rdata_reg;
  eamg_pkg::eamg_power_t act_inc_reg;
  eamg_pkg::eamg_power_t var_inc_reg;
  eamg_pkg::eamg_power_t pulse_pwr_reg;
  logic inc_valid_reg;
  eamg_pkg::eamg_power_t act_cond;
  eamg_pkg::eamg_power_t var_cond;
  logic wr_mode;
  logic wr_gain;
  logic wr_en;
  logic wr_status;
  logic sign_strobe;
  logic ap_neg;

  eamg_sign_if ap_sif ();
  eamg_sign_if var_sif ();

  assign wr_mode = sfr_wr && (sfr_addr == `EAMG_ADDR_ACC_MODE);
  assign wr_gain = sfr_wr && (sfr_addr == `EAMG_ADDR_GAIN);
  assign wr_en = sfr_wr && (sfr_addr == `EAMG_ADDR_IRQ_EN_LOW);
  assign wr_status = sfr_wr && (sfr_addr == `EAMG_ADDR_IRQ_ST_LOW);

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      acc_mode_reg <= `EAMG_ACC_MODE_RST;
    end else if (wr_mode) begin
      // Upper reserved bits are kept as written; software leaves them 0
      acc_mode_reg <= sfr_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      v_gain_reg <= 3'h0;
      i_gain_reg <= 3'h0;
      sign_src_reg <= eamg_pkg::EAMG_SRC_FILTERED;
    end else if (wr_gain) begin
      v_gain_reg <= sfr_wdata[`EAMG_GAIN_V_HI:`EAMG_GAIN_V_LO];
      i_gain_reg <= sfr_wdata[`EAMG_GAIN_I_HI:`EAMG_GAIN_I_LO];
      sign_src_reg <= eamg_pkg::eamg_sign_src_t'(
        sfr_wdata[`EAMG_GAIN_SIGN_SRC]);
    end
  end

  assign irq_en_next = wr_en ? sfr_wdata[4:0] : irq_en_reg;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_en_reg <= `EAMG_IRQ_EN_RST;
    end else begin
      irq_en_reg <= irq_en_next;
    end
  end

  // ------------------------------------------------------------
  // Power conditioning for the accumulators and pulse output
  // ------------------------------------------------------------
  // Magnitude saturates so the most negative code stays positive
  function automatic eamg_pkg::eamg_power_t mag(
    input eamg_pkg::eamg_power_t p
  );
    eamg_pkg::eamg_power_t r;
    r = p;
    if (p == 24'sh800000) begin
      r = 24'sh7FFFFF;
    end else if (p < 0) begin
      r = eamg_pkg::eamg_power_t'(-p);
    end
    return r;
  endfunction

  assign ap_neg = active_power < 0;

  always_comb begin
    // Absolute mode wins when both active modes are set
    if (acc_mode_reg[`EAMG_ACC_AP_ABS]) begin
      act_cond = mag(active_power);
    end else if (acc_mode_reg[`EAMG_ACC_AP_POS_ONLY]) begin
      act_cond = ap_neg ? 24'sh000000 : active_power;
    end else begin
      act_cond = active_power;
    end
  end

  always_comb begin
    if (acc_mode_reg[`EAMG_ACC_VAR_ABS]) begin
      var_cond = mag(reactive_power);
    end else if (acc_mode_reg[`EAMG_ACC_VAR_BY_AP] && ap_neg) begin
      var_cond = eamg_pkg::eamg_power_t'(-reactive_power);
    end else begin
      var_cond = reactive_power;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      act_inc_reg <= 24'sh000000;
      var_inc_reg <= 24'sh000000;
      pulse_pwr_reg <= 24'sh000000;
      inc_valid_reg <= 1'b0;
    end else begin
      inc_valid_reg <= power_valid;
      if (power_valid) begin
        act_inc_reg <= act_cond;
        // One value feeds the plain and read-with-reset accumulators
        var_inc_reg <= var_cond;
        pulse_pwr_reg <= pulse_on_reactive ? var_cond : act_cond;
      end
    end
  end

  // ------------------------------------------------------------
  // Sign-change detection
  // ------------------------------------------------------------
  assign sign_strobe = (sign_src_reg == eamg_pkg::EAMG_SRC_PULSE)
                       ? energy_pulse : power_valid;
  assign ap_sif.strobe = sign_strobe;
  assign ap_sif.neg = ap_neg;
  assign ap_sif.dir_rising = acc_mode_reg[`EAMG_ACC_AP_SIGN_EVT];
  assign var_sif.strobe = sign_strobe;
  assign var_sif.neg = reactive_power < 0;
  assign var_sif.dir_rising = acc_mode_reg[`EAMG_ACC_VAR_SIGN_EVT];

  eamg_sign_det u_ap_sign (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .sif(ap_sif.det)
  );

  eamg_sign_det u_var_sign (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .sif(var_sif.det)
  );

  // ------------------------------------------------------------
  // Status flags and summary
  // ------------------------------------------------------------
  always_comb begin
    status_set = 5'h00;
    status_set[`EAMG_ST_VAR_SIGN] = var_sif.evt;
    status_set[`EAMG_ST_AP_SIGN] = ap_sif.evt;
    status_set[`EAMG_ST_VA_NOLOAD] = apparent_noload_det
                                     || irms_noload_enter;
    status_set[`EAMG_ST_VAR_NOLOAD] = reactive_noload_det;
    status_set[`EAMG_ST_AP_NOLOAD] = active_noload_det;
  end

  // A new event wins over a clear in the same cycle
  assign status_next = (wr_status ? (status_reg & sfr_wdata[4:0])
                                  : status_reg) | status_set;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      status_reg <= `EAMG_IRQ_ST_RST;
    end else begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      summary_reg <= 1'b0;
    end else begin
      summary_reg <= |(status_next & irq_en_next);
    end
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        `EAMG_ADDR_ACC_MODE: begin
          rdata_reg <= acc_mode_reg;
        end
        `EAMG_ADDR_GAIN: begin
          rdata_reg <= {v_gain_reg, 1'b0, sign_src_reg, i_gain_reg};
        end
        `EAMG_ADDR_IRQ_EN_LOW: begin
          rdata_reg <= {3'h0, irq_en_reg};
        end
        `EAMG_ADDR_IRQ_ST_LOW: begin
          rdata_reg <= {summary_reg, 2'h0, status_reg};
        end
        default: begin
          rdata_reg <= 8'h00;
        end
      endcase
    end
  end

  assign sfr_rdata = rdata_reg;
  assign active_energy_inc = act_inc_reg;
  assign reactive_energy_inc = var_inc_reg;
  assign energy_inc_valid = inc_valid_reg;
  assign energy_pulse_power = pulse_pwr_reg;
  assign voltage_gain_sel = v_gain_reg;
  assign current_gain_sel = i_gain_reg;
  assign sign_detect_source = sign_src_reg;
  assign metering_irq = summary_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_summary;
    @(posedge clk_sys) disable iff (!rst_b)
    metering_irq == |(status_reg & irq_en_reg);
  endproperty
  a_summary: assert property (p_summary)
    else $error("summary does not match enabled flags");

  property p_enable_gate;
    @(posedge clk_sys) disable iff (!rst_b)
    (irq_en_reg == 5'h00 && !wr_en) |=> !metering_irq;
  endproperty
  a_enable_gate: assert property (p_enable_gate)
    else $error("interrupt pending with all enables clear");

  property p_var_sign_flag;
    @(posedge clk_sys) disable iff (!rst_b)
    var_sif.evt |=> status_reg[`EAMG_ST_VAR_SIGN];
  endproperty
  a_var_sign_flag: assert property (p_var_sign_flag)
    else $error("reactive sign event not flagged");

  property p_ap_sign_flag;
    @(posedge clk_sys) disable iff (!rst_b)
    ap_sif.evt |=> status_reg[`EAMG_ST_AP_SIGN];
  endproperty
  a_ap_sign_flag: assert property (p_ap_sign_flag)
    else $error("active sign event not flagged");

  property p_va_noload;
    @(posedge clk_sys) disable iff (!rst_b)
    (apparent_noload_det || irms_noload_enter)
      |=> status_reg[`EAMG_ST_VA_NOLOAD];
  endproperty
  a_va_noload: assert property (p_va_noload)
    else $error("apparent no-load not flagged");

  property p_var_noload;
    @(posedge clk_sys) disable iff (!rst_b)
    reactive_noload_det |=> status_reg[`EAMG_ST_VAR_NOLOAD];
  endproperty
  a_var_noload: assert property (p_var_noload)
    else $error("reactive no-load not flagged");

  property p_ap_noload;
    @(posedge clk_sys) disable iff (!rst_b)
    active_noload_det ##1 !active_noload_det
      |-> status_reg[`EAMG_ST_AP_NOLOAD];
  endproperty
  a_ap_noload: assert property (p_ap_noload)
    else $error("active no-load not flagged");

  property p_clear;
    @(posedge clk_sys) disable iff (!rst_b)
    (wr_status && !sfr_wdata[0] && !active_noload_det)
      |=> !status_reg[`EAMG_ST_AP_NOLOAD];
  endproperty
  a_clear: assert property (p_clear)
    else $error("flag not cleared by writing zero");

  property p_abs_active;
    @(posedge clk_sys) disable iff (!rst_b)
    (power_valid && acc_mode_reg[`EAMG_ACC_AP_ABS])
      |=> !active_energy_inc[23];
  endproperty
  a_abs_active: assert property (p_abs_active)
    else $error("absolute active increment is negative");

  property p_pos_only;
    @(posedge clk_sys) disable iff (!rst_b)
    (power_valid && acc_mode_reg[1:0] == 2'h2 && ap_neg)
      |=> active_energy_inc == 24'sh000000;
  endproperty
  a_pos_only: assert property (p_pos_only)
    else $error("negative active power accumulated");

  property p_abs_var;
    @(posedge clk_sys) disable iff (!rst_b)
    (power_valid && acc_mode_reg[`EAMG_ACC_VAR_ABS])
      |=> !reactive_energy_inc[23];
  endproperty
  a_abs_var: assert property (p_abs_var)
    else $error("absolute reactive increment is negative");

  property p_var_by_ap;
    @(posedge clk_sys) disable iff (!rst_b)
    (power_valid && acc_mode_reg[3:2] == 2'h1 && ap_neg
     && pulse_on_reactive)
      |=> reactive_energy_inc == -$past(reactive_power)
          && energy_pulse_power == reactive_energy_inc;
  endproperty
  a_var_by_ap: assert property (p_var_by_ap)
    else $error("reactive sign not inverted for negative active");

endmodule

// File: tb/eamg_cpu_model.sv
// Processor-side model driving the special function register bus
`timescale 1ns/1ps
`include "eamg_regs.svh"
module eamg_cpu_model (
  input wire logic clk_sys,
  output logic [7:0] sfr_addr,
  output logic sfr_wr,
  output logic sfr_rd,
  output logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata
);
  initial begin
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
  end

  // ----------------------------------------
  // Bus cycles; idle lines show the inverse
  // ----------------------------------------
  // Status writes carry ones for flags to keep, zeros to clear
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == `EAMG_ADDR_ACC_MODE) begin
      v[7:6] = 2'b00;
    end
    @(posedge clk_sys);
    #1;
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    sfr_wr = 1'b0;
    sfr_addr = ~a;
    sfr_wdata = ~v;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1;
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clk_sys);
    #1;
    sfr_rd = 1'b0;
    sfr_addr = ~a;
    d = sfr_rdata;
  endtask
endmodule

// File: tb/eamg_top_tb.sv
// Self-checking bench for the metering mode, gain and status bank
`timescale 1ns/1ps
`include "eamg_regs.svh"
module eamg_top_tb;
  logic clk_sys;
  logic rst_b;
  logic [7:0] sfr_addr;
  logic sfr_wr;
  logic sfr_rd;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  eamg_pkg::eamg_power_t active_power;
  eamg_pkg::eamg_power_t reactive_power;
  eamg_pkg::eamg_power_t a_inc;
  eamg_pkg::eamg_power_t r_inc;
  eamg_pkg::eamg_power_t p_pow;
  logic power_valid;
  logic energy_pulse;
  logic pulse_on_reactive;
  logic [3:0] nl;
  logic inc_valid;
  eamg_pkg::eamg_gain_code_t v_gain;
  eamg_pkg::eamg_gain_code_t i_gain;
  eamg_pkg::eamg_sign_src_t src;
  logic metering_irq;
  int n_fail = 0;
  int cmp_count = 0;
  int i;
  logic [2:0] g;

  eamg_cpu_model i_cpu (.clk_sys(clk_sys), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata));

  eamg_top i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .active_power(active_power),
    .reactive_power(reactive_power), .power_valid(power_valid),
    .energy_pulse(energy_pulse), .pulse_on_reactive(pulse_on_reactive),
    .active_noload_det(nl[0]), .reactive_noload_det(nl[1]),
    .apparent_noload_det(nl[2]), .irms_noload_enter(nl[3]),
    .active_energy_inc(a_inc), .reactive_energy_inc(r_inc),
    .energy_inc_valid(inc_valid), .energy_pulse_power(p_pow),
    .voltage_gain_sel(v_gain), .current_gain_sel(i_gain),
    .sign_detect_source(src), .metering_irq(metering_irq));

  // ----------------------------------------
  // Clock and helpers
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic cb(input logic s, input logic e);
    chk({23'h000000, s}, {23'h000000, e});
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_cpu.rd(a, d);
    chk({16'h0000, d}, {16'h0000, e});
  endtask

  task automatic pw(input eamg_pkg::eamg_power_t a,
                    input eamg_pkg::eamg_power_t r);
    @(posedge clk_sys);
    #1;
    active_power = a;
    reactive_power = r;
    power_valid = 1'b1;
    @(posedge clk_sys);
    #1;
    power_valid = 1'b0;
    cb(inc_valid, 1'b1);
  endtask

  task automatic acc(input logic [7:0] m, input eamg_pkg::eamg_power_t a,
    input eamg_pkg::eamg_power_t r, input logic pr,
    input eamg_pkg::eamg_power_t ea, input eamg_pkg::eamg_power_t er);
    i_cpu.wr(`EAMG_ADDR_ACC_MODE, m);
    pulse_on_reactive = pr;
    pw(a, r);
    chk(a_inc, ea);
    chk(r_inc, er);
    chk(p_pow, pr ? er : ea);
    // Valid is a one-cycle pulse; increments stand until the next sample
    @(posedge clk_sys);
    #1;
    cb(inc_valid, 1'b0);
    chk(a_inc, ea);
  endtask

  task automatic hit(input int k);
    @(posedge clk_sys);
    #1;
    nl[k] = 1'b1;
    @(posedge clk_sys);
    #1;
    nl[k] = 1'b0;
  endtask

  task automatic ep();
    @(posedge clk_sys);
    #1;
    energy_pulse = 1'b1;
    @(posedge clk_sys);
    #1;
    energy_pulse = 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  // Previous strobe sign p0, then p1 must flag, then back must not
  task automatic sgn(input logic ch, input logic dir);
    eamg_pkg::eamg_power_t p0;
    eamg_pkg::eamg_power_t p1;
    p0 = dir ? -24'sd100 : 24'sd100;
    p1 = -p0;
    i_cpu.wr(`EAMG_ADDR_ACC_MODE,
      ch ? {2'b00, dir, 5'h00} : {3'b000, dir, 4'h0});
    pw(ch ? 24'sd50 : p0, ch ? p0 : 24'sd50);
    repeat (3) @(posedge clk_sys);
    i_cpu.wr(`EAMG_ADDR_IRQ_ST_LOW, 8'h00);
    pw(ch ? 24'sd50 : p1, ch ? p1 : 24'sd50);
    repeat (3) @(posedge clk_sys);
    rchk(`EAMG_ADDR_IRQ_ST_LOW, ch ? 8'h90 : 8'h88);
    i_cpu.wr(`EAMG_ADDR_IRQ_ST_LOW, 8'h00);
    pw(ch ? 24'sd50 : p0, ch ? p0 : 24'sd50);
    repeat (3) @(posedge clk_sys);
    rchk(`EAMG_ADDR_IRQ_ST_LOW, 8'h00);
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys);
    n_fail++;
    close_out();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    rst_b = 1'b0;
    active_power = 24'sd0;
    reactive_power = 24'sd0;
    power_valid = 1'b0;
    energy_pulse = 1'b0;
    pulse_on_reactive = 1'b0;
    nl = 4'h0;
    repeat (4) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    chk({21'h000000, v_gain}, 24'h000000);
    chk({21'h000000, i_gain}, 24'h000000);
    cb(src, 1'b0);
    rchk(`EAMG_ADDR_ACC_MODE, 8'h00);
    rchk(`EAMG_ADDR_GAIN, 8'h00);
    rchk(`EAMG_ADDR_IRQ_EN_LOW, 8'h00);
    rchk(`EAMG_ADDR_IRQ_ST_LOW, 8'h00);
    i_cpu.wr(8'h10, 8'h5A);
    rchk(8'h10, 8'h00);
    for (i = 0; i < 5; i++) begin
      g = i[2:0];
      i_cpu.wr(`EAMG_ADDR_GAIN, {g, 2'b00, g});
      chk({21'h000000, v_gain}, {21'h000000, g});
      chk({21'h000000, i_gain}, {21'h000000, g});
    end
    i_cpu.wr(`EAMG_ADDR_GAIN, 8'hFF);
    rchk(`EAMG_ADDR_GAIN, 8'hEF);
    i_cpu.wr(`EAMG_ADDR_GAIN, 8'h00);
    acc(8'h00, -24'sd5, -24'sd7, 1'b0, -24'sd5, -24'sd7);
    acc(8'h01, -24'sd5, 24'sd7, 1'b0, 24'sd5, 24'sd7);
    acc(8'h02, -24'sd5, 24'sd7, 1'b0, 24'sd0, 24'sd7);
    acc(8'h02, 24'sd6, 24'sd7, 1'b0, 24'sd6, 24'sd7);
    acc(8'h08, -24'sd5, -24'sd7, 1'b1, -24'sd5, 24'sd7);
    acc(8'h04, -24'sd5, 24'sd7, 1'b1, -24'sd5, -24'sd7);
    acc(8'h04, 24'sd5, -24'sd7, 1'b1, 24'sd5, -24'sd7);
    repeat (3) @(posedge clk_sys);
    i_cpu.wr(`EAMG_ADDR_IRQ_ST_LOW, 8'h00);
    i_cpu.wr(`EAMG_ADDR_IRQ_EN_LOW, 8'h1F);
    for (i = 0; i < 4; i++) begin
      hit(i);
      rchk(`EAMG_ADDR_IRQ_ST_LOW, 8'h80 | (8'h01 << (i < 3 ? i : 2)));
      cb(metering_irq, 1'b1);
      i_cpu.wr(`EAMG_ADDR_IRQ_ST_LOW, 8'h00);
      rchk(`EAMG_ADDR_IRQ_ST_LOW, 8'h00);
      cb(metering_irq, 1'b0);
    end
    hit(0);
    hit(1);
    i_cpu.wr(`EAMG_ADDR_IRQ_ST_LOW, 8'hFE);
    rchk(`EAMG_ADDR_IRQ_ST_LOW, 8'h82);
    i_cpu.wr(`EAMG_ADDR_IRQ_EN_LOW, 8'h1D);
    rchk(`EAMG_ADDR_IRQ_ST_LOW, 8'h02);
    cb(metering_irq, 1'b0);
    i_cpu.wr(`EAMG_ADDR_IRQ_EN_LOW, 8'hFF);
    rchk(`EAMG_ADDR_IRQ_EN_LOW, 8'h1F);
    cb(metering_irq, 1'b1);
    i_cpu.wr(`EAMG_ADDR_IRQ_EN_LOW, 8'h18);
    sgn(1'b0, 1'b0);
    sgn(1'b0, 1'b1);
    sgn(1'b1, 1'b0);
    sgn(1'b1, 1'b1);
    i_cpu.wr(`EAMG_ADDR_ACC_MODE, 8'h00);
    i_cpu.wr(`EAMG_ADDR_GAIN, 8'h08);
    cb(src, 1'b1);
    pw(24'sd50, 24'sd50);
    ep();
    i_cpu.wr(`EAMG_ADDR_IRQ_ST_LOW, 8'h00);
    pw(-24'sd50, 24'sd50);
    repeat (3) @(posedge clk_sys);
    rchk(`EAMG_ADDR_IRQ_ST_LOW, 8'h00);
    ep();
    rchk(`EAMG_ADDR_IRQ_ST_LOW, 8'h88);
    close_out();
  end
endmodule
